//--- hdl/sfsr_pkg.sv
// constants, opcodes and types for the serial flash status-write and read block
package sfsr_pkg;

    // instruction codes
    localparam logic [7:0]  OP_WREN    = 8'h06;
    localparam logic [7:0]  OP_WRDI    = 8'h04;
    localparam logic [7:0]  OP_VWREN   = 8'h50;
    localparam logic [7:0]  OP_WRSR1   = 8'h01;
    localparam logic [7:0]  OP_WRSR2   = 8'h31;
    localparam logic [7:0]  OP_RDSR1   = 8'h05;
    localparam logic [7:0]  OP_RDSR2   = 8'h35;
    localparam logic [7:0]  OP_READ    = 8'h03;
    localparam logic [7:0]  OP_FAST    = 8'h0B;
    localparam logic [7:0]  OP_DOUT    = 8'h3B;
    localparam logic [7:0]  OP_QOUT    = 8'h6B;
    localparam logic [7:0]  OP_DIO     = 8'hBB;
    localparam logic [7:0]  OP_QIO     = 8'hEB;
    localparam logic [7:0]  OP_WRAP    = 8'h77;

    // status word layout: bits 7:0 first register, 15:8 second register
    localparam int          BIT_BUSY   = 0;
    localparam int          BIT_WEL    = 1;
    localparam int          BIT_SRL    = 8;
    localparam int          BIT_QE     = 9;
    localparam logic [15:0] SR_WR_MASK = 16'h7FFC;
    localparam logic [15:0] LOCK_MASK  = 16'h3C00;
    localparam logic [15:0] VOL_KEEP   = 16'h3D00;
    localparam logic [15:0] SR_RST     = 16'h0000;

    // wrap_setting_bits {W6,W5,wrap_disable_bit}
    localparam logic [2:0]  WRAP_RST   = 3'h1;

    // link clock counts, in rising edges since chip select fell
    localparam logic [6:0]  CNT_OP     = 7'h08;
    localparam logic [6:0]  CNT_BYTE1  = 7'h10;
    localparam logic [6:0]  CNT_BYTE2  = 7'h18;
    localparam logic [6:0]  CNT_WBITS  = 7'h0E;
    localparam logic [6:0]  CNT_SAT    = 7'h7F;
    localparam logic [6:0]  END_A1     = 7'h20;
    localparam logic [6:0]  END_A2     = 7'h14;
    localparam logic [6:0]  END_A4     = 7'h0E;
    localparam logic [6:0]  START_READ = 7'h20;
    localparam logic [6:0]  START_FAST = 7'h28;
    localparam logic [6:0]  START_DIO  = 7'h18;
    localparam logic [6:0]  START_QIO  = 7'h14;

    // timing
    localparam int          SYS_CLK_PERIOD_NS           = 4;
    localparam int          STATUS_WRITE_CYCLE_TIME_NS  = 10000000;
    localparam int          STATUS_WRITE_CYCLES_DEF     =
        (STATUS_WRITE_CYCLE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        CK_NONE, CK_WREN, CK_WRDI, CK_VWREN, CK_WRSR1, CK_WRSR12, CK_WRSR2, CK_WRAP
    } sfsr_commit_t;

    typedef enum logic [3:0] {
        RK_IGN, RK_STAT1, RK_STAT2, RK_READ, RK_FAST, RK_DOUT, RK_QOUT, RK_DIO, RK_QIO
    } sfsr_rd_t;

endpackage

//--- hdl/sfsr_top.sv
// serial flash status-write, write-enable and read-family instruction logic
// Contract
// - status write touches only bits 7..2 and 14..8; others read-only
// - lock bits are one-time: once 1 they never return to 0
// - non-volatile status write accepted only while write-enable latch is 1
// - volatile write needs 50h first and leaves write-enable latch at 0
// - volatile write cannot clear status lock bit or lock bits 3..1
// - power loss drops volatile values; power-up reloads stored status
// - status write executes only if ended after exactly 8 or 16 data bits
// - 01h ended after 8 bits leaves second status register unchanged
// - non-volatile write runs self-timed cycle with busy 1, status reads allowed
// - end of non-volatile write cycle clears write-enable latch
// - volatile write applies promptly after chip select rises, busy stays 0
// - 03h takes opcode and 24-bit address, shifts data MSB first
// - reads auto-increment address per byte and stream until chip select rises
// - read instructions while busy are ignored without disturbing the cycle
// - 0Bh and 3Bh insert eight dummy clocks after the address
// - 6Bh accepted only with quad enable; four bits per clock after dummies
// - BBh takes address and returns data two bits per clock
// - EBh quad address and data, four dummy clocks, needs quad enable
// - wrapped quad I/O read loops within its 8..64-byte section
// - three wrap bits: lowest disables wrap, upper two select length
// - length codes 8,16,32,64 bytes; wrap on when disable bit 0; resets 1
// - 06h sets write-enable latch; 04h clears it and volatile enable
`timescale 1ns/1ns
`default_nettype none

module sfsr_top #(
    parameter int STATUS_WRITE_CYCLES = sfsr_pkg::STATUS_WRITE_CYCLES_DEF
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        SPI_CLK,
    input  wire logic        CS_N,
    input  wire logic [3:0]  IO_IN,
    output var  logic [3:0]  IO_OUT,
    output var  logic [3:0]  IO_OE,
    output var  logic [23:0] MEM_ADDR,
    input  wire logic [7:0]  MEM_RDATA,
    input  wire logic [15:0] NV_STATUS_IN,
    output var  logic [15:0] NV_WR_DATA,
    output var  logic        NV_WR_STB
);

    // link side, rising edge, cleared whenever chip select is high
    typedef struct packed {
        logic [6:0]        cnt;
        logic [7:0]        op;
        sfsr_pkg::sfsr_rd_t kind;
        logic [23:0]       addr;
        logic [2:0]        beat;
        logic              stream;
        logic              load;
    } sfsr_frame_t;

    // link side, rising edge, survives between frames
    typedef struct packed {
        logic [15:0]            st_s1;
        logic [15:0]            st_s2;
        logic [2:0]             wr_s1;
        logic [2:0]             wr_s2;
        sfsr_pkg::sfsr_commit_t commit;
        logic [15:0]            cdata;
        logic                   tog;
    } sfsr_keep_t;

    // link side, falling edge output stage
    typedef struct packed {
        logic [7:0] sr;
        logic [3:0] io_o;
        logic [3:0] io_oe;
    } sfsr_out_t;

    // system clock side
    typedef struct packed {
        logic        cs_s1;
        logic        cs_s2;
        logic        cs_s3;
        logic        tog_s1;
        logic        tog_s2;
        logic        tog_seen;
        logic        boot;
        logic [15:0] sr;
        logic        write_enable_latch;
        logic        vwel;
        logic        busy;
        logic [23:0] timer;
        logic [15:0] pend;
        logic [2:0]  wrap;
        logic [15:0] nv_data;
        logic        nv_stb;
    } sfsr_sys_t;

    sfsr_frame_t a_q, a_d;
    sfsr_keep_t  b_q, b_d;
    sfsr_out_t   c_q, c_d;
    sfsr_sys_t   s_q, s_d;

    logic        frame_rst_n;
    logic [6:0]  nc;
    logic [7:0]  op_full;
    logic [7:0]  src_byte;
    logic [15:0] st_vec;

    // chip select high ends any frame at once, clocks or not
    assign frame_rst_n = RST_N & ~CS_N;

    function automatic sfsr_pkg::sfsr_rd_t decode(input logic [7:0] op,
                                                  input logic busy,
                                                  input logic qe);
        case (op)
            sfsr_pkg::OP_RDSR1: decode = sfsr_pkg::RK_STAT1;
            sfsr_pkg::OP_RDSR2: decode = sfsr_pkg::RK_STAT2;
            sfsr_pkg::OP_READ:  decode = busy ? sfsr_pkg::RK_IGN : sfsr_pkg::RK_READ;
            sfsr_pkg::OP_FAST:  decode = busy ? sfsr_pkg::RK_IGN : sfsr_pkg::RK_FAST;
            sfsr_pkg::OP_DOUT:  decode = busy ? sfsr_pkg::RK_IGN : sfsr_pkg::RK_DOUT;
            sfsr_pkg::OP_QOUT:  decode = (busy || !qe) ? sfsr_pkg::RK_IGN
                                                       : sfsr_pkg::RK_QOUT;
            sfsr_pkg::OP_DIO:   decode = busy ? sfsr_pkg::RK_IGN : sfsr_pkg::RK_DIO;
            sfsr_pkg::OP_QIO:   decode = (busy || !qe) ? sfsr_pkg::RK_IGN
                                                       : sfsr_pkg::RK_QIO;
            default:            decode = sfsr_pkg::RK_IGN;
        endcase
    endfunction

    function automatic logic [2:0] addr_lanes(input sfsr_pkg::sfsr_rd_t k);
        case (k)
            sfsr_pkg::RK_DIO: addr_lanes = 3'h2;
            sfsr_pkg::RK_QIO: addr_lanes = 3'h4;
            default:          addr_lanes = 3'h1;
        endcase
    endfunction

    function automatic logic [2:0] out_lanes(input sfsr_pkg::sfsr_rd_t k);
        case (k)
            sfsr_pkg::RK_DOUT, sfsr_pkg::RK_DIO:  out_lanes = 3'h2;
            sfsr_pkg::RK_QOUT, sfsr_pkg::RK_QIO:  out_lanes = 3'h4;
            default:                              out_lanes = 3'h1;
        endcase
    endfunction

    function automatic logic [6:0] addr_end(input sfsr_pkg::sfsr_rd_t k);
        case (k)
            sfsr_pkg::RK_READ, sfsr_pkg::RK_FAST,
            sfsr_pkg::RK_DOUT, sfsr_pkg::RK_QOUT: addr_end = sfsr_pkg::END_A1;
            sfsr_pkg::RK_DIO:                     addr_end = sfsr_pkg::END_A2;
            sfsr_pkg::RK_QIO:                     addr_end = sfsr_pkg::END_A4;
            default:                              addr_end = 7'h00;
        endcase
    endfunction

    // mode bits and dummies are counted through, never stored
    function automatic logic [6:0] data_start(input sfsr_pkg::sfsr_rd_t k);
        case (k)
            sfsr_pkg::RK_STAT1, sfsr_pkg::RK_STAT2: data_start = sfsr_pkg::CNT_OP;
            sfsr_pkg::RK_READ: data_start = sfsr_pkg::START_READ;
            sfsr_pkg::RK_FAST, sfsr_pkg::RK_DOUT,
            sfsr_pkg::RK_QOUT: data_start = sfsr_pkg::START_FAST;
            sfsr_pkg::RK_DIO:  data_start = sfsr_pkg::START_DIO;
            sfsr_pkg::RK_QIO:  data_start = sfsr_pkg::START_QIO;
            default:           data_start = sfsr_pkg::CNT_SAT;
        endcase
    endfunction

    function automatic logic [23:0] next_addr(input logic [23:0] a,
                                              input sfsr_pkg::sfsr_rd_t k,
                                              input logic [2:0] w);
        logic [7:0] m;
        logic [7:0] inc;
        m   = 8'h00;
        inc = a[7:0] + 8'h01;
        case (w[2:1])
            2'h0:    m = 8'h07;
            2'h1:    m = 8'h0F;
            2'h2:    m = 8'h1F;
            default: m = 8'h3F;
        endcase
        if (k == sfsr_pkg::RK_QIO && !w[0]) begin
            next_addr = {a[23:8], (a[7:0] & ~m) | (inc & m)};
        end else begin
            next_addr = a + 24'h000001;
        end
    endfunction

    function automatic logic [15:0] merge(input sfsr_pkg::sfsr_commit_t k,
                                          input logic [15:0] d,
                                          input logic [15:0] cur,
                                          input logic [15:0] keep);
        logic [15:0] n;
        n = cur;
        case (k)
            sfsr_pkg::CK_WRSR1:  n[7:2] = d[7:2];
            sfsr_pkg::CK_WRSR12: begin
                n[7:2]  = d[15:10];
                n[14:8] = d[6:0];
            end
            sfsr_pkg::CK_WRSR2:  n[14:8] = d[6:0];
            default:             n = cur;
        endcase
        merge = (n & sfsr_pkg::SR_WR_MASK) | (cur & keep);
    endfunction

    // ---------------- link rising edge ----------------
    always_comb begin
        a_d      = a_q;
        nc       = (a_q.cnt == sfsr_pkg::CNT_SAT) ? a_q.cnt : a_q.cnt + 7'h01;
        op_full  = {a_q.op[6:0], IO_IN[0]};
        a_d.cnt  = nc;
        a_d.load = 1'b0;
        if (a_q.cnt < sfsr_pkg::CNT_OP) begin
            a_d.op = op_full;
        end
        if (nc == sfsr_pkg::CNT_OP) begin
            a_d.kind = decode(op_full, b_q.st_s2[sfsr_pkg::BIT_BUSY],
                              b_q.st_s2[sfsr_pkg::BIT_QE]);
        end
        if (a_q.cnt >= sfsr_pkg::CNT_OP && a_q.cnt < addr_end(a_q.kind)) begin
            case (addr_lanes(a_q.kind))
                3'h2:    a_d.addr = {a_q.addr[21:0], IO_IN[1:0]};
                3'h4:    a_d.addr = {a_q.addr[19:0], IO_IN[3:0]};
                default: a_d.addr = {a_q.addr[22:0], IO_IN[0]};
            endcase
        end
        if (a_d.kind != sfsr_pkg::RK_IGN) begin
            if (!a_q.stream && nc == data_start(a_d.kind)) begin
                a_d.stream = 1'b1;
                a_d.load   = 1'b1;
                a_d.beat   = 3'h0;
            end else if (a_q.stream) begin
                if (a_q.beat == (3'h7 >> (out_lanes(a_q.kind) >> 1))) begin
                    a_d.beat = 3'h0;
                    a_d.load = 1'b1;
                    if (a_q.kind != sfsr_pkg::RK_STAT1 && a_q.kind != sfsr_pkg::RK_STAT2) begin
                        a_d.addr = next_addr(a_q.addr, a_q.kind, b_q.wr_s2);
                    end
                end else begin
                    a_d.beat = a_q.beat + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge SPI_CLK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            a_q <= '{cnt: 7'h00, op: 8'h00, kind: sfsr_pkg::RK_IGN, addr: 24'h000000,
                     beat: 3'h0, stream: 1'b0, load: 1'b0};
        end else begin
            a_q <= a_d;
        end
    end

    // verdict of the frame so far; the last edge before chip select rises decides
    always_comb begin
        b_d        = b_q;
        b_d.st_s1  = st_vec;
        b_d.st_s2  = b_q.st_s1;
        b_d.wr_s1  = s_q.wrap;
        b_d.wr_s2  = b_q.wr_s1;
        b_d.commit = sfsr_pkg::CK_NONE;
        if (a_q.cnt == 7'h00) begin
            b_d.tog = ~b_q.tog;
        end
        if (a_q.cnt >= sfsr_pkg::CNT_OP
            && (a_q.op == sfsr_pkg::OP_WRSR1 || a_q.op == sfsr_pkg::OP_WRSR2)) begin
            b_d.cdata = {b_q.cdata[14:0], IO_IN[0]};
        end
        if (a_q.cnt == sfsr_pkg::CNT_WBITS && a_q.op == sfsr_pkg::OP_WRAP) begin
            b_d.cdata = {13'h0000, IO_IN[2:0]};
        end
        if (nc == sfsr_pkg::CNT_OP) begin
            case (op_full)
                sfsr_pkg::OP_WREN:  b_d.commit = sfsr_pkg::CK_WREN;
                sfsr_pkg::OP_WRDI:  b_d.commit = sfsr_pkg::CK_WRDI;
                sfsr_pkg::OP_VWREN: b_d.commit = sfsr_pkg::CK_VWREN;
                default:            b_d.commit = sfsr_pkg::CK_NONE;
            endcase
        end else if (nc == sfsr_pkg::CNT_BYTE1) begin
            case (a_q.op)
                sfsr_pkg::OP_WRSR1: b_d.commit = sfsr_pkg::CK_WRSR1;
                sfsr_pkg::OP_WRSR2: b_d.commit = sfsr_pkg::CK_WRSR2;
                sfsr_pkg::OP_WRAP:  b_d.commit = sfsr_pkg::CK_WRAP;
                default:            b_d.commit = sfsr_pkg::CK_NONE;
            endcase
        end else if (nc == sfsr_pkg::CNT_BYTE2 && a_q.op == sfsr_pkg::OP_WRSR1) begin
            b_d.commit = sfsr_pkg::CK_WRSR12;
        end
    end

    always_ff @(posedge SPI_CLK or negedge RST_N) begin
        if (!RST_N) begin
            b_q <= '{st_s1: 16'h0000, st_s2: 16'h0000, wr_s1: sfsr_pkg::WRAP_RST,
                     wr_s2: sfsr_pkg::WRAP_RST, commit: sfsr_pkg::CK_NONE,
                     cdata: 16'h0000, tog: 1'b0};
        end else begin
            b_q <= b_d;
        end
    end

    // ---------------- link falling edge ----------------
    always_comb begin
        c_d      = c_q;
        src_byte = c_q.sr;
        if (a_q.load) begin
            case (a_q.kind)
                sfsr_pkg::RK_STAT1: src_byte = b_q.st_s2[7:0];
                sfsr_pkg::RK_STAT2: src_byte = b_q.st_s2[15:8];
                default:            src_byte = MEM_RDATA;
            endcase
        end
        if (a_q.stream) begin
            case (out_lanes(a_q.kind))
                3'h2: begin
                    c_d.io_o  = {2'h0, src_byte[7:6]};
                    c_d.io_oe = 4'h3;
                    c_d.sr    = {src_byte[5:0], 2'h0};
                end
                3'h4: begin
                    c_d.io_o  = src_byte[7:4];
                    c_d.io_oe = 4'hF;
                    c_d.sr    = {src_byte[3:0], 4'h0};
                end
                default: begin
                    c_d.io_o  = {2'h0, src_byte[7], 1'b0};
                    c_d.io_oe = 4'h2;
                    c_d.sr    = {src_byte[6:0], 1'b0};
                end
            endcase
        end else begin
            c_d.io_oe = 4'h0;
        end
    end

    always_ff @(negedge SPI_CLK or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            c_q <= '{sr: 8'h00, io_o: 4'h0, io_oe: 4'h0};
        end else begin
            c_q <= c_d;
        end
    end

    // ---------------- system clock side ----------------
    // commit and cdata hold still while chip select is high and the link clock idles,
    // so the synced toggle is enough to qualify them; a very short gap is a hazard
    always_comb begin
        s_d        = s_q;
        s_d.cs_s1  = CS_N;
        s_d.cs_s2  = s_q.cs_s1;
        s_d.cs_s3  = s_q.cs_s2;
        s_d.tog_s1 = b_q.tog;
        s_d.tog_s2 = s_q.tog_s1;
        s_d.nv_stb = 1'b0;
        if (s_q.boot) begin
            s_d.boot = 1'b0;
            s_d.sr   = NV_STATUS_IN & sfsr_pkg::SR_WR_MASK;
        end else if (s_q.busy) begin
            if (s_q.timer == 24'h000000) begin
                s_d.busy    = 1'b0;
                s_d.write_enable_latch     = 1'b0;
                s_d.sr      = s_q.pend;
                s_d.nv_data = s_q.pend;
                s_d.nv_stb  = 1'b1;
            end else begin
                s_d.timer = s_q.timer - 24'h000001;
            end
        end
        if (s_q.cs_s2 && !s_q.cs_s3 && s_q.tog_s2 != s_q.tog_seen) begin
            s_d.tog_seen = s_q.tog_s2;
            // busy refuses everything that changes state
            if (!s_q.busy && !s_q.boot) begin
                case (b_q.commit)
                    sfsr_pkg::CK_WREN:  s_d.write_enable_latch = 1'b1;
                    sfsr_pkg::CK_WRDI:  begin
                        s_d.write_enable_latch  = 1'b0;
                        s_d.vwel = 1'b0;
                    end
                    sfsr_pkg::CK_VWREN: s_d.vwel = 1'b1;
                    sfsr_pkg::CK_WRAP:  s_d.wrap = b_q.cdata[2:0];
                    sfsr_pkg::CK_WRSR1, sfsr_pkg::CK_WRSR12, sfsr_pkg::CK_WRSR2: begin
                        if (s_q.write_enable_latch) begin
                            s_d.busy  = 1'b1;
                            s_d.timer = 24'(STATUS_WRITE_CYCLES - 1);
                            s_d.pend  = merge(b_q.commit, b_q.cdata, s_q.sr,
                                              sfsr_pkg::LOCK_MASK);
                        end else if (s_q.vwel) begin
                            s_d.vwel = 1'b0;
                            s_d.sr   = merge(b_q.commit, b_q.cdata, s_q.sr,
                                             sfsr_pkg::VOL_KEEP);
                        end
                    end
                    default: s_d.tog_seen = s_q.tog_s2;
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            s_q <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_s3: 1'b1, tog_s1: 1'b0, tog_s2: 1'b0,
                     tog_seen: 1'b0, boot: 1'b1, sr: sfsr_pkg::SR_RST, write_enable_latch: 1'b0,
                     vwel: 1'b0, busy: 1'b0, timer: 24'h000000, pend: sfsr_pkg::SR_RST,
                     wrap: sfsr_pkg::WRAP_RST, nv_data: sfsr_pkg::SR_RST, nv_stb: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // status seen by reads: busy and latch bits live, sus bit reads 0
    assign st_vec = {1'b0, s_q.sr[14:2], s_q.write_enable_latch, s_q.busy};

    assign IO_OUT     = c_q.io_o;
    assign IO_OE      = c_q.io_oe;
    assign MEM_ADDR   = a_q.addr;
    assign NV_WR_DATA = s_q.nv_data;
    assign NV_WR_STB  = s_q.nv_stb;

endmodule // sfsr_top

`default_nettype wire

//--- tb/sfsr_assertions.sv
// port assertions for the status-write and read block
`timescale 1ns/1ns
`default_nettype none
module sfsr_chk #(
    parameter int STATUS_WRITE_CYCLES = 20
) (
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        CS_N,
    input wire logic [3:0]  IO_OE,
    input wire logic [23:0] MEM_ADDR,
    input wire logic [15:0] NV_STATUS_IN,
    input wire logic [15:0] NV_WR_DATA,
    input wire logic        NV_WR_STB
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_idle; CS_N && $past(CS_N); endsequence
    sequence s_live; !CS_N && $past(!CS_N) && $past(IO_OE) != 4'h0; endsequence
    a_oe_idle: assert property (s_idle |-> IO_OE == 4'h0)
        else $error("lines driven while deselected");
    a_addr_idle: assert property (s_idle |-> MEM_ADDR == 24'h0)
        else $error("address kept after frame");
    a_oe_legal: assert property (!CS_N |-> IO_OE inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("odd line set driven");
    a_oe_hold: assert property (s_live |-> IO_OE == $past(IO_OE))
        else $error("drive dropped in frame");
    a_stb_pulse: assert property (NV_WR_STB |=> !NV_WR_STB [*8])
        else $error("store strobe too long");
    a_stb_data: assert property (NV_WR_STB |=> $stable(NV_WR_DATA))
        else $error("store word moved");
    a_lock_keep: assert property (NV_WR_STB |->
        (NV_WR_DATA & NV_STATUS_IN & 16'h3C00) == (NV_STATUS_IN & 16'h3C00))
        else $error("lock bit cleared");
    a_top_zero: assert property (NV_WR_STB |-> NV_WR_DATA[15] == 1'b0)
        else $error("read-only bit stored");
endmodule // sfsr_chk
bind sfsr_top sfsr_chk #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_chk (.SYS_CLK, .RST_N,
    .CS_N, .IO_OE, .MEM_ADDR, .NV_STATUS_IN, .NV_WR_DATA, .NV_WR_STB);
`default_nettype wire

//--- tb/sfsr_host.sv
// spi host model driving frames on the link
`timescale 1ns/1ns
`default_nettype none
module sfsr_host (
    input  wire logic [3:0]  IO,
    output var  logic        SPI_CLK,
    output var  logic        CS_N,
    output var  logic [3:0]  HD,
    output var  logic [31:0] RD
);
    event got;
    initial begin
        SPI_CLK = 1'b0;
        CS_N = 1'b1;
        HD = 4'hF;
        RD = 32'h0;
    end
    // clock runs only in frames; released lines toggle so no stale level reads as data
    task automatic frame(input logic [7:0] op, input int wi, ni, input logic [47:0] din,
                         input int wo, no);
        logic [55:0] sh;
        sh = {op, din};
        RD = 32'h0;
        CS_N = 1'b0;
        for (int i = 0; i < 8 + ni + no; i++) begin
            if (i < 8 + ni) begin
                HD = (i < 8 || wi == 1) ? {3'h7, sh[55]} :
                     (wi == 2) ? {2'h3, sh[55:54]} : sh[55:52];
                sh = sh << ((i < 8) ? 1 : wi);
            end else
                HD = ~HD;
            #32 SPI_CLK = 1'b1;
            if (i >= 8 + ni)
                RD = (RD << wo) | (wo == 1 ? 32'(IO[1]) : wo == 2 ? 32'(IO[1:0]) : 32'(IO));
            #32 SPI_CLK = 1'b0;
        end
        #32 CS_N = 1'b1;
        if (no > 0) ->got;
        #40;
    endtask
endmodule // sfsr_host
`default_nettype wire

//--- tb/sfsr_top_tb.sv
// self-checking bench for the status-write and read block
`timescale 1ns/1ns
`default_nettype none
module sfsr_top_tb;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        spi_clk, cs_n, nv_stb;
    logic [3:0]  io_out, io_oe, hd;
    wire  [3:0]  io = (io_oe & io_out) | (~io_oe & hd);
    logic [23:0] mem_addr, a;
    logic [15:0] nv_data, nv_store = 16'h04A4;
    logic [31:0] rd, q[$];
    int          seed = 83352, miscompares = 0, checks = 0, n;
    int          tw[6][5] = '{'{8'h03, 1, 24, 1, 16}, '{8'h0B, 1, 32, 1, 16},
        '{8'h3B, 1, 32, 2, 8}, '{8'h6B, 1, 32, 4, 4}, '{8'hBB, 2, 16, 2, 8}, '{8'hEB, 4, 12, 4, 4}};
    always #2 sys_clk = ~sys_clk;
    sfsr_top #(.STATUS_WRITE_CYCLES(2000)) u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
        .SPI_CLK(spi_clk), .CS_N(cs_n), .IO_IN(io), .IO_OUT(io_out), .IO_OE(io_oe),
        .MEM_ADDR(mem_addr), .MEM_RDATA(mem_addr[7:0] ^ 8'hA5), .NV_STATUS_IN(nv_store),
        .NV_WR_DATA(nv_data), .NV_WR_STB(nv_stb));
    sfsr_host u_host (.IO(io), .SPI_CLK(spi_clk), .CS_N(cs_n), .HD(hd), .RD(rd));
    function automatic logic [7:0] m(input logic [23:0] x);
        return x[7:0] ^ 8'hA5;
    endfunction
    task automatic chk(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rs(input logic [7:0] op, e);
        q.push_back({24'h0, e});
        u_host.frame(op, 1, 0, 48'h0, 1, 8);
    endtask
    task automatic cmd(input logic [7:0] op, input int ni, input logic [15:0] d);
        u_host.frame(op, 1, ni, {d, 32'h0}, 1, 0);
    endtask
    task drain;
        for (n = 0; n < 4000 && q.size() > 0; n++) @(posedge sys_clk);
        if (q.size() > 0) begin
            miscompares++;
            tally_and_finish;
        end
    endtask
    initial forever begin
        @(u_host.got);
        chk(rd, q.pop_front());
    end
    // stored word model: sampled off the launching edge, reloaded by the block at reset
    always @(negedge sys_clk) if (nv_stb === 1'b1) begin
        chk({16'h0, nv_data & 16'h7FFC}, q.pop_front());
        nv_store <= nv_data;
    end
    initial begin
        #200000;
        miscompares++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(negedge sys_clk);
        #1;
        rs(8'h05, 8'hA4);
        rs(8'h35, 8'h04);
        // refused quad read: lines stay undriven, so the host reads back its own toggling
        q.push_back(32'h1E1E);
        u_host.frame(8'h6B, 1, 32, 48'h0, 4, 4);
        cmd(8'h06, 0, 16'h0);
        rs(8'h05, 8'hA6);
        cmd(8'h01, 12, 16'hFFF0);
        rs(8'h05, 8'hA6);
        cmd(8'h01, 16, 16'hA782);
        rs(8'h05, 8'hA7);
        q.push_back(32'h55);
        u_host.frame(8'h03, 1, 24, 48'h0, 1, 8);
        q.push_back(32'h06A4);
        drain;
        rs(8'h05, 8'hA4);
        rs(8'h35, 8'h06);
        for (int k = 0; k < 6; k++) begin
            a = 24'($random(seed));
            q.push_back({16'h0, m(a), m(a + 24'h1)});
            u_host.frame(8'(tw[k][0]), tw[k][1], tw[k][2], {a, 24'hFFFFFF}, tw[k][3], tw[k][4]);
        end
        u_host.frame(8'h77, 4, 8, 48'hFFFFFF0F0000, 1, 0);
        a = {a[23:3], 3'h6};
        q.push_back({m(a), m(a + 24'h1), m({a[23:3], 3'h0}), m({a[23:3], 3'h1})});
        u_host.frame(8'hEB, 4, 12, {a, 24'hFFFFFF}, 4, 8);
        cmd(8'h06, 0, 16'h0);
        cmd(8'h50, 0, 16'h0);
        cmd(8'h04, 0, 16'h0);
        cmd(8'h01, 8, 16'h0000);
        rs(8'h05, 8'hA4);
        cmd(8'h50, 0, 16'h0);
        cmd(8'h01, 8, 16'h5C00);
        rs(8'h05, 8'h5C);
        rs(8'h35, 8'h06);
        drain;
        // power cycle: volatile value lost, stored word and wrap-off default return
        @(negedge sys_clk) rst_n <= 1'b0;
        repeat (6) @(negedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(negedge sys_clk);
        #1;
        rs(8'h05, 8'hA4);
        rs(8'h35, 8'h06);
        q.push_back({m(a), m(a + 24'h1), m(a + 24'h2), m(a + 24'h3)});
        u_host.frame(8'hEB, 4, 12, {a, 24'hFFFFFF}, 4, 8);
        drain;
        tally_and_finish;
    end
endmodule // sfsr_top_tb
`default_nettype wire
